/* File: src/gpioi_pint_ch.sv */
// Purpose: one pin interrupt channel, level or edge
// Assumes: sample already synchronised to i_clk
// Notes: edge flag is sticky until cleared; set beats clear
`timescale 1ns/1ns
module gpioi_pint_ch
	import gpioi_pkg::*;
(
	input wire logic i_clk, // system clock
	input wire logic i_arst_n, // async reset, low
	input wire logic i_smp, // synchronised pin sample
	input wire gpioi_pint_cfg_t i_cfg, // channel setup
	input wire logic i_clr, // clear edge flag
	output logic o_flag, // edge flag state
	output logic o_irq // interrupt request
);
	logic prev_q;
	logic flag_q;
	logic irq_q;
	logic edge_set;

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			prev_q <= 1'b0;
		else
			prev_q <= i_smp;
	end

	// edge is a change against the previous cycle's sample
	assign edge_set = i_cfg.en && !i_cfg.level &&
		((i_cfg.rise && i_smp && !prev_q) || (i_cfg.fall && !i_smp && prev_q)); // RULE_14

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			flag_q <= 1'b0;
		else
			flag_q <= edge_set || (flag_q && !i_clr); // RULE_07
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			irq_q <= 1'b0;
		else if (i_cfg.level)
			irq_q <= i_cfg.en && (i_smp == i_cfg.act_high); // RULE_07
		else
			irq_q <= flag_q || edge_set;
	end

	assign o_flag = flag_q;
	assign o_irq = irq_q;
endmodule

/* File: src/gpioi_pkg.sv */
// Purpose: shared constants and types of the general purpose I/O block
// Assumes: one 16 kB slot per peripheral, word registers inside it
// Notes: pin index covers up to 64 pins
package gpioi_pkg;
	localparam int NPORT_DEF = 2;
	localparam int PW_DEF = 32;
	localparam int NPINT = 8;
	localparam int NGRP = 2;
	localparam int PIN_IDX_W = 6;
	localparam int SLOT_W = 14;
	// slot base is arbitrary; only the bits above SLOT_W are compared
	localparam logic [31:0] SLOT_BASE = 32'h4800_0000;

	localparam logic [13:0] OFF_PINB = 14'h0000;
	localparam logic [13:0] OFF_DIR = 14'h2000;
	localparam logic [13:0] OFF_PORT = 14'h2100;
	localparam logic [13:0] OFF_SET = 14'h2200;
	localparam logic [13:0] OFF_CLR = 14'h2280;
	localparam logic [13:0] OFF_PINT_CFG = 14'h3000;
	localparam logic [13:0] OFF_PINT_CLR = 14'h3040;
	localparam logic [13:0] OFF_PINT_FLAG = 14'h3044;
	localparam logic [13:0] OFF_GRP = 14'h3100;
	localparam logic [13:0] GRP_STRIDE = 14'h0020;
	localparam logic [13:0] GRP_POL = 14'h0010;
	localparam logic [13:0] GRP_CTL = 14'h001C;

	localparam int CTL_EN = 0;
	localparam int CTL_AND = 1;

	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	typedef struct packed {
		logic en;
		logic act_high;
		logic fall;
		logic rise;
		logic level;
		logic [1:0] rsvd;
		logic [PIN_IDX_W-1:0] sel;
	} gpioi_pint_cfg_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [31:0] addr;
		logic [31:0] wdata;
	} gpioi_bus_t;
endpackage

/* File: src/gpioi_top.sv */
// Purpose: general purpose I/O ports with pin and group interrupts
// Assumes: pins sampled on I_CLK; write/read port in a private 16 kB slot
// Notes: read data appears one cycle after the read strobe
//
// How it works
// RULE_01 - pins not claimed by a peripheral are sensed and, as outputs, driven here
// RULE_02 - direction per pin can change any time by a plain write
// RULE_03 - set and clear writes change many pins, others untouched
// RULE_04 - one port write loads every output bit of a port
// RULE_05 - per-pin byte registers read or drive one pin alone
// RULE_06 - after reset all pins are inputs, all interrupts disabled
// RULE_07 - pin interrupt on level, rising, falling or both edges
// RULE_08 - eight channels each pick any pin and raise own request
// RULE_09 - two group units each combine pins from all ports
// RULE_10 - group mask lets any pin or pin set of a port trigger
// RULE_11 - registers sit on the fast system bus port directly
// RULE_12 - slot hit compares only address bits above 16 kB
// RULE_13 - each unit drives one interrupt line
// RULE_14 - inputs synchronised, edge is change from previous sample
// RULE_15 - group matches pattern of levels, all-match or any-match
`timescale 1ns/1ns
module gpioi_top
	import gpioi_pkg::*;
#(
	parameter int NPORT = NPORT_DEF,
	parameter int PW = PW_DEF
)
(
	input wire logic I_CLK, // system clock
	input wire logic I_ARST_N, // async reset, low
	input wire gpioi_bus_t I_BUS, // register access strobes
	input wire logic [NPORT*PW-1:0] I_PIO_IN, // pin levels
	input wire logic [NPORT*PW-1:0] I_FUNC_CLAIM, // pin owned by other peripheral
	output logic [NPORT*PW-1:0] O_PIO_OUT, // pin output values
	output logic [NPORT*PW-1:0] O_PIO_OE, // pin output enables
	output logic [31:0] O_RDATA, // read data
	output logic O_RVALID, // read data valid pulse
	output logic [NPINT-1:0] O_PINT_IRQ, // pin interrupt lines
	output logic [NGRP-1:0] O_GRP_IRQ // group interrupt lines
);
	localparam int NPIN = NPORT * PW;

	if (PW != 32 || NPORT < 1 || NPORT > 2)
		$error("gpioi_top: PW must be 32 and NPORT 1 or 2");

	function automatic logic [13:0] word_off(input logic [13:0] base, input int idx);
		return base + 14'(idx * 4);
	endfunction

	logic [NPIN-1:0] meta_q;
	logic [NPIN-1:0] sync_q;
	logic [NPIN-1:0] dir_q;
	logic [NPIN-1:0] out_q;
	logic [NPIN-1:0] oe_q;
	logic [31:0] rdata_q;
	logic rvalid_q;
	gpioi_pint_cfg_t pint_cfg_q [NPINT];
	logic [NPINT-1:0] pint_clr;
	logic [NPINT-1:0] pint_flag;
	logic [NPIN-1:0] grp_ena_q [NGRP];
	logic [NPIN-1:0] grp_pol_q [NGRP];
	logic [1:0] grp_ctl_q [NGRP];
	logic [NGRP-1:0] grp_irq_q;
	logic [NPIN-1:0] grp_hit [NGRP];
	logic slot_hit;
	logic wr_hit;
	logic rd_hit;
	logic [13:0] off;

	// only the upper bits select, so the slot decodes cheaply
	assign slot_hit = I_BUS.addr[31:SLOT_W] == SLOT_BASE[31:SLOT_W]; // RULE_12
	assign wr_hit = I_BUS.wr && slot_hit; // RULE_11
	assign rd_hit = I_BUS.rd && slot_hit;
	assign off = I_BUS.addr[SLOT_W-1:0];

	// first stage feeds only the second
	always_ff @(posedge I_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			meta_q <= '0;
		else
			meta_q <= I_PIO_IN;
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			sync_q <= '0;
		else
			sync_q <= meta_q; // RULE_14
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			dir_q <= '0; // RULE_06
		else if (wr_hit)
		begin
			for (int p = 0; p < NPORT; p++)
				if (off == word_off(OFF_DIR, p))
					dir_q[p*PW +: PW] <= I_BUS.wdata[PW-1:0]; // RULE_02
		end
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			out_q <= '0;
		else if (wr_hit)
		begin
			if (off < 14'(NPIN))
				out_q[off[PIN_IDX_W-1:0]] <= I_BUS.wdata[0]; // RULE_05
			for (int p = 0; p < NPORT; p++)
			begin
				if (off == word_off(OFF_PORT, p))
					out_q[p*PW +: PW] <= I_BUS.wdata[PW-1:0]; // RULE_04
				if (off == word_off(OFF_SET, p))
					out_q[p*PW +: PW] <= out_q[p*PW +: PW] | I_BUS.wdata[PW-1:0]; // RULE_03
				if (off == word_off(OFF_CLR, p))
					out_q[p*PW +: PW] <= out_q[p*PW +: PW] & ~I_BUS.wdata[PW-1:0]; // RULE_03
			end
		end
	end

	// a claimed pin is released even if software left it as output
	always_ff @(posedge I_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			oe_q <= '0;
		else
			oe_q <= dir_q & ~I_FUNC_CLAIM; // RULE_01
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			for (int c = 0; c < NPINT; c++)
				pint_cfg_q[c] <= gpioi_pint_cfg_t'(RST_WORD[12:0]); // RULE_06
		end
		else if (wr_hit)
		begin
			for (int c = 0; c < NPINT; c++)
				if (off == word_off(OFF_PINT_CFG, c))
					pint_cfg_q[c] <= gpioi_pint_cfg_t'(I_BUS.wdata[12:0]); // RULE_08
		end
	end

	assign pint_clr = (wr_hit && off == OFF_PINT_CLR) ? I_BUS.wdata[NPINT-1:0] : '0;

	for (genvar c = 0; c < NPINT; c++)
	begin : g_pint
		gpioi_pint_ch u_ch (
			.i_clk(I_CLK),
			.i_arst_n(I_ARST_N),
			.i_smp(sync_q[pint_cfg_q[c].sel]), // RULE_08
			.i_cfg(pint_cfg_q[c]),
			.i_clr(pint_clr[c]),
			.o_flag(pint_flag[c]),
			.o_irq(O_PINT_IRQ[c]) // RULE_13
		);
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			for (int g = 0; g < NGRP; g++)
			begin
				grp_ena_q[g] <= '0;
				grp_pol_q[g] <= '0;
				grp_ctl_q[g] <= '0; // RULE_06
			end
		end
		else if (wr_hit)
		begin
			for (int g = 0; g < NGRP; g++)
			begin
				for (int p = 0; p < NPORT; p++)
				begin
					if (off == word_off(OFF_GRP + 14'(g) * GRP_STRIDE, p))
						grp_ena_q[g][p*PW +: PW] <= I_BUS.wdata[PW-1:0]; // RULE_10
					if (off == word_off(OFF_GRP + 14'(g) * GRP_STRIDE + GRP_POL, p))
						grp_pol_q[g][p*PW +: PW] <= I_BUS.wdata[PW-1:0];
				end
				if (off == OFF_GRP + 14'(g) * GRP_STRIDE + GRP_CTL)
					grp_ctl_q[g] <= I_BUS.wdata[1:0];
			end
		end
	end

	// per-pin match against the programmed level, masked by the enable set
	always_comb
	begin
		for (int g = 0; g < NGRP; g++)
			grp_hit[g] = ~(sync_q ^ grp_pol_q[g]) & grp_ena_q[g]; // RULE_15
	end

	// level-driven: the line follows the pattern, no latch to clear
	always_ff @(posedge I_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			grp_irq_q <= '0;
		else
		begin
			for (int g = 0; g < NGRP; g++)
			begin
				if (grp_ctl_q[g][CTL_AND])
					grp_irq_q[g] <= grp_ctl_q[g][CTL_EN] && (|grp_ena_q[g]) &&
						((grp_hit[g] | ~grp_ena_q[g]) == '1); // RULE_09
				else
					grp_irq_q[g] <= grp_ctl_q[g][CTL_EN] && (|grp_hit[g]); // RULE_09
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			rdata_q <= RST_WORD;
		else if (rd_hit)
		begin
			rdata_q <= RST_WORD;
			if (off < 14'(NPIN))
				rdata_q <= {31'h0000_0000, sync_q[off[PIN_IDX_W-1:0]]}; // RULE_05
			for (int p = 0; p < NPORT; p++)
			begin
				if (off == word_off(OFF_DIR, p))
					rdata_q <= dir_q[p*PW +: PW];
				if (off == word_off(OFF_PORT, p))
					rdata_q <= sync_q[p*PW +: PW]; // RULE_01
				if (off == word_off(OFF_SET, p))
					rdata_q <= out_q[p*PW +: PW];
			end
			for (int c = 0; c < NPINT; c++)
				if (off == word_off(OFF_PINT_CFG, c))
					rdata_q <= {19'h0_0000, pint_cfg_q[c]};
			if (off == OFF_PINT_FLAG)
				rdata_q <= {24'h00_0000, pint_flag};
			for (int g = 0; g < NGRP; g++)
			begin
				for (int p = 0; p < NPORT; p++)
				begin
					if (off == word_off(OFF_GRP + 14'(g) * GRP_STRIDE, p))
						rdata_q <= grp_ena_q[g][p*PW +: PW];
					if (off == word_off(OFF_GRP + 14'(g) * GRP_STRIDE + GRP_POL, p))
						rdata_q <= grp_pol_q[g][p*PW +: PW];
				end
				if (off == OFF_GRP + 14'(g) * GRP_STRIDE + GRP_CTL)
					rdata_q <= {30'h0000_0000, grp_ctl_q[g]};
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			rvalid_q <= 1'b0;
		else
			rvalid_q <= rd_hit;
	end

	assign O_PIO_OUT = out_q;
	assign O_PIO_OE = oe_q;
	assign O_RDATA = rdata_q;
	assign O_RVALID = rvalid_q;
	assign O_GRP_IRQ = grp_irq_q; // RULE_13
endmodule

/* File: tb/gpioi_pin_env.sv */
// Purpose: external circuits on the pins
// Assumes: a pin not driven by the block follows i_ext
// Notes: claimed pins are not modelled
`timescale 1ns/1ns
module gpioi_pin_env
#(
	parameter int N = 64
)
(
	input wire logic [N-1:0] i_out, // block out values
	input wire logic [N-1:0] i_oe, // block enables
	input wire logic [N-1:0] i_ext, // outside levels
	output logic [N-1:0] o_pin // pad level
);
	assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule

/* File: tb/gpioi_top_checker.sv */
// Purpose: port checks of the I/O block
// Assumes: one clock domain
// Notes: offsets within the slot come from the package
`timescale 1ns/1ns
module gpioi_top_checker
	import gpioi_pkg::*;
#(
	parameter int NPORT = NPORT_DEF,
	parameter int PW = PW_DEF
)
(
	input wire logic I_CLK, // clock
	input wire logic I_ARST_N, // reset, low
	input wire gpioi_bus_t I_BUS, // strobes
	input wire logic [NPORT*PW-1:0] I_FUNC_CLAIM, // claims
	input wire logic [NPORT*PW-1:0] O_PIO_OUT, // outs
	input wire logic [NPORT*PW-1:0] O_PIO_OE, // enables
	input wire logic [31:0] O_RDATA, // read data
	input wire logic O_RVALID // read valid
);
	logic hit;
	logic rhit;
	logic [13:0] off;
	logic [31:0] wd;
	assign hit = I_BUS.addr[31:14] == SLOT_BASE[31:14];
	assign rhit = I_BUS.rd && hit;
	assign off = I_BUS.addr[13:0];
	assign wd = I_BUS.wdata;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_ARST_N);
	rd_answer_a: assert property (rhit |=> O_RVALID)
		else $error("read hit without valid");
	rd_stray_a: assert property (O_RVALID |-> $past(rhit))
		else $error("valid without read hit");
	rdata_hold_a: assert property (!$past(rhit) |-> $stable(O_RDATA))
		else $error("read data moved");
	set_write_a: assert property (I_BUS.wr && hit && off == OFF_SET |=>
		O_PIO_OUT[31:0] == ($past(O_PIO_OUT[31:0]) | $past(wd))) else $error("set write wrong");
	clr_write_a: assert property (I_BUS.wr && hit && off == OFF_CLR |=>
		O_PIO_OUT[31:0] == ($past(O_PIO_OUT[31:0]) & ~$past(wd))) else $error("clear write wrong");
	port_write_a: assert property (I_BUS.wr && hit && off == OFF_PORT |=>
		O_PIO_OUT[31:0] == $past(wd)) else $error("port write wrong");
	out_cause_a: assert property ($changed(O_PIO_OUT) |-> $past(I_BUS.wr))
		else $error("out changed without write");
	oe_cause_a: assert property ($changed(O_PIO_OE) |-> $past(I_BUS.wr, 2) ||
		$past(I_FUNC_CLAIM) != $past(I_FUNC_CLAIM, 2)) else $error("enable changed without cause");
	oe_claim_a: assert property ((O_PIO_OE & $past(I_FUNC_CLAIM)) == '0)
		else $error("claimed pin driven");
endmodule

/* File: tb/test_gpioi_top.sv */
// Purpose: directed test of the I/O block
// Assumes: two ports of 32 pins
// Notes: waits of five cycles cover the three-cycle pin path
`timescale 1ns/1ns
module test_gpioi_top
	import gpioi_pkg::*;
;
	logic clk, rst_n, rvalid;
	gpioi_bus_t bus;
	logic [63:0] ext, pin, claim, out, oe;
	logic [31:0] rdata;
	logic [7:0] pirq;
	logic [1:0] girq;
	int mismatches, total_checks;
	logic [31:0] cfg [4] = '{32'h0000_1200, 32'h0000_1900, 32'h0000_1400, 32'h0000_1600};
	gpioi_top u_dut (.I_CLK(clk), .I_ARST_N(rst_n), .I_BUS(bus), .I_PIO_IN(pin), .I_FUNC_CLAIM(claim),
		.O_PIO_OUT(out), .O_PIO_OE(oe), .O_RDATA(rdata), .O_RVALID(rvalid), .O_PINT_IRQ(pirq), .O_GRP_IRQ(girq));
	gpioi_pin_env u_env (.i_out(out), .i_oe(oe), .i_ext(ext), .o_pin(pin));
	task chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [13:0] off, input logic [31:0] d);
		@(posedge clk) bus <= '{wr: 1'b1, rd: 1'b0, addr: SLOT_BASE + 32'(off), wdata: d};
		@(posedge clk) bus <= '0;
	endtask
	task rd(input logic [13:0] off, input logic [31:0] exp);
		@(posedge clk) bus <= '{wr: 1'b0, rd: 1'b1, addr: SLOT_BASE + 32'(off), wdata: 32'h0000_0000};
		@(posedge clk) bus <= '0;
		#1;
		chk(64'(rvalid), 64'h1);
		chk(64'(rdata), 64'(exp));
	endtask
	task settle;
		repeat (5) @(posedge clk);
		#1;
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard: a stuck run still reaches the verdict
	initial
	begin
		repeat (5000) @(posedge clk);
		mismatches++;
		end_sim;
	end
	initial
	begin
		rst_n = 1'b0;
		bus = '0;
		ext = '0;
		claim = '0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk(oe, 64'h0);
		chk(64'({pirq, girq}), 64'h0);
		$display("reset test done");
		wr(OFF_DIR, 32'hFFFF_0000);
		wr(OFF_PORT, 32'hA5A5_0000);
		wr(OFF_SET, 32'h0F00_0000);
		wr(OFF_CLR, 32'hA000_0000);
		wr(OFF_PINB + 14'h0011, 32'h0000_0001);
		rd(OFF_SET, 32'h0FA7_0000);
		chk(64'(out[31:0]), 64'(32'h0FA7_0000));
		chk(64'(oe[31:0]), 64'(32'hFFFF_0000));
		rd(OFF_DIR, 32'hFFFF_0000);
		rd(OFF_PORT, 32'h0FA7_0000);
		rd(OFF_PINB + 14'h0010, 32'h0000_0001);
		rd(14'h1000, 32'h0000_0000);
		// the next slot up must neither answer nor take the write
		@(posedge clk) bus <= '{wr: 1'b1, rd: 1'b1, addr: SLOT_BASE + 32'h0000_4000 + 32'(OFF_PORT),
			wdata: 32'h0000_0000};
		@(posedge clk) bus <= '0;
		#1;
		chk(64'(rvalid), 64'h0);
		chk(64'(out[31:0]), 64'(32'h0FA7_0000));
		@(posedge clk) claim[31:16] <= 16'hFFFF;
		settle;
		chk(64'(oe[31:0]), 64'h0);
		$display("port test done");
		for (int i = 0; i < 4; i++)
			wr(OFF_PINT_CFG + 14'(4 * i), cfg[i] | 32'(i + 8));
		@(posedge clk) ext[11:8] <= 4'hF;
		// two sync stages, then the channel flop: nothing before the third edge
		repeat (2) @(posedge clk);
		#1;
		chk(64'(pirq), 64'h0);
		@(posedge clk);
		#1;
		chk(64'(pirq), 64'(8'h0B));
		rd(OFF_PINT_FLAG, 32'h0000_0009);
		rd(OFF_PINT_CFG + 14'h0004, 32'h0000_1909);
		wr(OFF_PINT_CLR, 32'h0000_000F);
		@(posedge clk) ext[11:8] <= 4'h0;
		settle;
		chk(64'(pirq), 64'(8'h0C));
		$display("pin irq test done");
		wr(OFF_GRP, 32'h0000_3000);
		wr(OFF_GRP + GRP_POL, 32'h0000_3000);
		wr(OFF_GRP + GRP_CTL, 32'h0000_0003);
		wr(OFF_GRP + GRP_STRIDE + 14'h0004, 32'h0000_0001);
		wr(OFF_GRP + GRP_STRIDE + GRP_CTL, 32'h0000_0001);
		rd(OFF_GRP + GRP_STRIDE + GRP_CTL, 32'h0000_0001);
		@(posedge clk) ext[12] <= 1'b1;
		settle;
		chk(64'(girq), 64'(2'b10));
		@(posedge clk) ext[33:32] <= 2'b01;
		ext[13] <= 1'b1;
		settle;
		chk(64'(girq), 64'(2'b01));
		wr(OFF_GRP + GRP_CTL, 32'h0000_0001);
		@(posedge clk) ext[13] <= 1'b0;
		settle;
		chk(64'(girq), 64'(2'b01));
		$display("group test done");
		end_sim;
	end
endmodule

bind gpioi_top gpioi_top_checker #(.NPORT(NPORT), .PW(PW)) u_chk (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
	.I_BUS(I_BUS), .I_FUNC_CLAIM(I_FUNC_CLAIM), .O_PIO_OUT(O_PIO_OUT), .O_PIO_OE(O_PIO_OE),
	.O_RDATA(O_RDATA), .O_RVALID(O_RVALID));
